// >>> inc/rtc_host_defines.svh
// Register map, field positions, reset values and timing of the RTC host
`ifndef RTC_HOST_DEFINES_SVH
`define RTC_HOST_DEFINES_SVH
`define CLK_HZ       100000000
`define CLK_NS       10
`define POWERON_MS   500
`define READBACK_MS  1000
`define SCL_QTR_NS   2500
`define REC_CLOCKS   63
`define DEV_CODE     4'h6
`define OFF_CTRL     8'h00
`define OFF_STAT     8'h04
`define OFF_TXLO     8'h08
`define OFF_TXHI     8'h0c
`define OFF_RXLO     8'h10
`define OFF_RXHI     8'h14
`define CTRL_GO      0
`define CFG_LO       1
`define CFG_HI       8
`define W1C_LO       2
`define W1C_HI       5
`define CTRL_RST     8'h00
`endif

// >>> inc/rtc_host_pkg.sv
// Types shared by the RTC host controller and its line engine
package rtc_host_pkg;
   typedef enum logic [1:0] {OP_START = 2'b00, OP_STOP = 2'b01, OP_BIT = 2'b10} op_t;
   typedef enum logic [2:0] {
      S_HOLD  = 3'b000,
      S_IDLE  = 3'b001,
      S_START = 3'b010,
      S_BYTE  = 3'b011,
      S_ACK   = 3'b100,
      S_STOP  = 3'b101,
      S_REC   = 3'b110
   } st_t;
   typedef struct packed {
      logic [2:0] cmd;
      logic       rec;
      logic [2:0] nb;
      logic       rw;
   } ctrl_t;
   typedef struct packed {
      logic late;
      logic conflict;
      logic order;
      logic nack;
      logic ready;
      logic busy;
   } stat_t;
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic       hit;
      logic [7:0] addr;
   } ahb_req_t;
endpackage

// >>> src/line_bit_engine.sv
// Two-wire line engine: start, stop and single bit slots in four quarter phases
`timescale 1ns/100ps
`default_nettype none
`include "rtc_host_defines.svh"
module line_bit_engine #(
   parameter int QTR_CYC = (`SCL_QTR_NS + `CLK_NS - 1) / `CLK_NS
) (
   input  wire logic                ref_clk,
   input  wire logic                resetn,
   input  wire logic                op_go,
   input  wire rtc_host_pkg::op_t   op_kind,
   input  wire logic                op_bit,
   input  wire logic                sda_i,
   output logic                     op_done,
   output logic                     rx_bit,
   output logic                     scl_oe,
   output logic                     sda_oe
);
   localparam int CW = $clog2(QTR_CYC + 1);
   rtc_host_pkg::op_t kind, next_kind;
   logic [CW-1:0]     cnt, next_cnt;
   logic [1:0]        ph, next_ph;
   logic [1:0]        lv;
   logic              act, next_act, bit_v, next_bit, next_rx, next_done;
   logic              next_scl_oe, next_sda_oe, sda_m, sda_s;

   // Line levels {scl, sda} per phase; a one means released
   function automatic logic [1:0] lines(input rtc_host_pkg::op_t k, input logic [1:0] p, input logic b);
      case (k)
         rtc_host_pkg::OP_START: lines = (p == 2'h0) ? 2'h3 : ((p == 2'h1) ? 2'h2 : 2'h0);
         rtc_host_pkg::OP_STOP:  lines = (p == 2'h0) ? 2'h0 : ((p == 2'h1) ? 2'h2 : 2'h3);
         default:                lines = {(p == 2'h1) || (p == 2'h2), b};
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sda_m <= 1'h1;
         sda_s <= 1'h1;
      end else begin
         sda_m <= sda_i;
         sda_s <= sda_m;
      end
   end

   always_comb begin
      next_act  = act;
      next_ph   = ph;
      next_cnt  = cnt;
      next_kind = kind;
      next_bit  = bit_v;
      next_rx   = rx_bit;
      next_done = 1'h0;
      if (!act) begin
         if (op_go) begin
            next_act  = 1'h1;
            next_ph   = 2'h0;
            next_cnt  = '0;
            next_kind = op_kind;
            next_bit  = op_bit;
         end
      end else if (cnt == CW'(QTR_CYC - 1)) begin
         next_cnt = '0;
         next_ph  = ph + 2'h1;
         // Sample a quarter after the rising clock edge
         if (ph == 2'h1) begin
            next_rx = sda_s;
         end
         if (ph == 2'h3) begin
            next_act  = 1'h0;
            next_done = 1'h1;
         end
      end else begin
         next_cnt = cnt + 1'h1;
      end
      lv = lines(next_kind, next_ph, next_bit);
      // Idle keeps the last levels, so a held-low data line stays low
      next_scl_oe = next_act ? !lv[1] : scl_oe;
      next_sda_oe = next_act ? !lv[0] : sda_oe;
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         act     <= 1'h0;
         ph      <= 2'h0;
         cnt     <= '0;
         kind    <= rtc_host_pkg::OP_BIT;
         bit_v   <= 1'h1;
         rx_bit  <= 1'h1;
         op_done <= 1'h0;
         scl_oe  <= 1'h0;
         sda_oe  <= 1'h0;
      end else begin
         act     <= next_act;
         ph      <= next_ph;
         cnt     <= next_cnt;
         kind    <= next_kind;
         bit_v   <= next_bit;
         rx_bit  <= next_rx;
         op_done <= next_done;
         scl_oe  <= next_scl_oe;
         sda_oe  <= next_sda_oe;
      end
   end
endmodule // line_bit_engine
`default_nettype wire

// >>> src/rtc_host.sv
// Host controller: AHB-Lite registers and two-wire transfer sequencer for the RTC
`timescale 1ns/100ps
`default_nettype none
`include "rtc_host_defines.svh"
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module rtc_host #(
   parameter int         HOLD_CYC = `POWERON_MS * (`CLK_HZ / 1000),
   parameter int         LATE_CYC = `READBACK_MS * (`CLK_HZ / 1000),
   parameter int         QTR_CYC  = (`SCL_QTR_NS + `CLK_NS - 1) / `CLK_NS,
   parameter logic [2:0] CMD_ST2  = 3'h1,
   parameter logic [1:0] CMD_INT  = 2'h2,
   parameter logic [7:0] ALARM_ON = 8'h20,
   parameter logic [7:0] FREQ_ON  = 8'h40
) (
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam int LW = $clog2(LATE_CYC + 1);
   rtc_host_pkg::ahb_req_t req, next_req;
   rtc_host_pkg::st_t      st, next_st;
   rtc_host_pkg::ctrl_t    cfg, next_cfg;
   rtc_host_pkg::stat_t    flags, next_flags;
   rtc_host_pkg::op_t      op_kind, next_op_kind;
   logic [31:0]            next_hrdata;
   logic [63:0]            txd, next_txd, rxd, next_rxd;
   logic [HW-1:0]          hold_cnt, next_hold_cnt;
   logic [LW-1:0]          late_cnt, next_late_cnt;
   logic [7:0]             shreg, next_shreg;
   logic [5:0]             rec_cnt, next_rec_cnt;
   logic [2:0]             bit_cnt, next_bit_cnt, byte_idx, next_byte_idx;
   logic                   op_go, next_op_go, op_bit, next_op_bit, pend, next_pend;
   logic                   rec_mode, next_rec_mode, st2_done, next_st2_done;
   logic                   armed, next_armed, op_done, rx_bit, is_tx, last, wr_hit;

   line_bit_engine #(.QTR_CYC(QTR_CYC)) u_line (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .op_go   (op_go),
      .op_kind (op_kind),
      .op_bit  (op_bit),
      .sda_i   (sda_i),
      .op_done (op_done),
      .rx_bit  (rx_bit),
      .scl_oe  (scl_oe),
      .sda_oe  (sda_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Zero-wait slave; read data is taken from the address phase
   always_comb begin
      next_req    = '0;
      next_hrdata = hrdata;
      if (hsel && hready && htrans[1]) begin
         next_req.valid = 1'h1;
         next_req.wr    = hwrite;
         next_req.hit   = (haddr[31:8] == 24'h0);
         next_req.addr  = haddr[7:0];
         if (!hwrite) begin
            next_hrdata = 32'h0;
            if (haddr[31:8] == 24'h0) begin
               case (haddr[7:0])
                  `OFF_CTRL: next_hrdata = {23'h0, cfg, 1'h0};
                  `OFF_STAT: next_hrdata = {26'h0, flags};
                  `OFF_TXLO: next_hrdata = txd[31:0];
                  `OFF_TXHI: next_hrdata = txd[63:32];
                  `OFF_RXLO: next_hrdata = rxd[31:0];
                  `OFF_RXHI: next_hrdata = rxd[63:32];
                  default:   next_hrdata = 32'h0;
               endcase
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         req       <= '0;
         hrdata    <= 32'h0;
         hreadyout <= 1'h1;
         hresp     <= 1'h0;
      end else begin
         req       <= next_req;
         hrdata    <= next_hrdata;
         hreadyout <= 1'h1;
         hresp     <= 1'h0;
      end
   end

   assign wr_hit = req.valid && req.wr && req.hit;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      next_st       = st;
      next_cfg      = cfg;
      next_flags    = flags;
      next_op_go    = 1'h0;
      next_op_kind  = op_kind;
      next_op_bit   = op_bit;
      next_pend     = pend;
      next_rec_mode = rec_mode;
      next_st2_done = st2_done;
      next_armed    = armed;
      next_bit_cnt  = bit_cnt;
      next_byte_idx = byte_idx;
      next_rec_cnt  = rec_cnt;
      next_shreg    = shreg;
      next_txd      = txd;
      next_rxd      = rxd;
      next_hold_cnt = hold_cnt;
      next_late_cnt = late_cnt;
      is_tx         = (byte_idx == 3'h0) || !cfg.rw;
      last          = (byte_idx == cfg.nb);
      // Software writes; sticky clears come first so hardware sets win
      if (wr_hit) begin
         case (req.addr)
            `OFF_CTRL: begin
               if (st == rtc_host_pkg::S_IDLE) begin
                  next_cfg = rtc_host_pkg::ctrl_t'(hwdata[`CFG_HI:`CFG_LO]);
                  if (hwdata[`CTRL_GO]) begin
                     if (!next_cfg.rec && next_cfg.cmd[2:1] == CMD_INT && !st2_done) begin
                        next_flags.order = 1'h1;
                     end else if (!next_cfg.rec && next_cfg.cmd == CMD_ST2 && !next_cfg.rw
                                  && (txd[7:0] & ALARM_ON) == ALARM_ON
                                  && (txd[7:0] & FREQ_ON) == FREQ_ON) begin
                        next_flags.conflict = 1'h1;
                     end else begin
                        next_st       = rtc_host_pkg::S_START;
                        next_rec_mode = next_cfg.rec;
                        next_byte_idx = 3'h0;
                        next_shreg    = {`DEV_CODE, next_cfg.cmd, next_cfg.rw};
                     end
                  end
               end
            end
            `OFF_STAT: next_flags[`W1C_HI:`W1C_LO] = flags[`W1C_HI:`W1C_LO] & ~hwdata[`W1C_HI:`W1C_LO];
            `OFF_TXLO: next_txd[31:0] = hwdata;
            `OFF_TXHI: next_txd[63:32] = hwdata;
            default: ;
         endcase
      end
      if (armed) begin
         if (late_cnt == '0) begin
            next_armed      = 1'h0;
            next_flags.late = 1'h1;
         end else begin
            next_late_cnt = late_cnt - 1'h1;
         end
      end
      case (st)
         rtc_host_pkg::S_HOLD: begin
            if (hold_cnt == '0) begin
               next_st       = rtc_host_pkg::S_START;
               next_rec_mode = 1'h1;
            end else begin
               next_hold_cnt = hold_cnt - 1'h1;
            end
         end
         rtc_host_pkg::S_IDLE: ;
         default: begin
            if (!pend) begin
               next_op_go   = 1'h1;
               next_pend    = 1'h1;
               next_op_kind = rtc_host_pkg::OP_BIT;
               next_op_bit  = 1'h1;
               case (st)
                  rtc_host_pkg::S_START: next_op_kind = rtc_host_pkg::OP_START;
                  rtc_host_pkg::S_STOP:  next_op_kind = rtc_host_pkg::OP_STOP;
                  rtc_host_pkg::S_BYTE:  next_op_bit = is_tx ? shreg[7] : 1'h1;
                  rtc_host_pkg::S_ACK:   next_op_bit = is_tx ? 1'h1 : last;
                  default:               next_op_bit = 1'h1;
               endcase
            end else if (op_done) begin
               next_pend = 1'h0;
               case (st)
                  rtc_host_pkg::S_START: begin
                     next_rec_cnt = 6'h0;
                     next_bit_cnt = 3'h0;
                     next_st      = rec_mode ? rtc_host_pkg::S_REC : rtc_host_pkg::S_BYTE;
                  end
                  rtc_host_pkg::S_REC: begin
                     if (rec_cnt == 6'(`REC_CLOCKS - 1)) begin
                        next_st = rtc_host_pkg::S_STOP;
                     end else begin
                        next_rec_cnt = rec_cnt + 6'h1;
                     end
                  end
                  rtc_host_pkg::S_BYTE: begin
                     next_shreg = {shreg[6:0], rx_bit};
                     if (bit_cnt == 3'h7) begin
                        next_st = rtc_host_pkg::S_ACK;
                     end else begin
                        next_bit_cnt = bit_cnt + 3'h1;
                     end
                  end
                  rtc_host_pkg::S_ACK: begin
                     if (!is_tx) begin
                        next_rxd[{byte_idx - 3'h1, 3'h0} +: 8] = shreg;
                        if (last) begin
                           next_armed = 1'h0;
                        end
                     end
                     if (is_tx && rx_bit) begin
                        next_flags.nack = 1'h1;
                        next_st         = rtc_host_pkg::S_STOP;
                     end else if (last) begin
                        next_st = rtc_host_pkg::S_STOP;
                        if (!cfg.rw) begin
                           next_armed    = 1'h1;
                           next_late_cnt = LW'(LATE_CYC - 1);
                           if (cfg.cmd == CMD_ST2) begin
                              next_st2_done = 1'h1;
                           end
                        end
                     end else begin
                        next_byte_idx = byte_idx + 3'h1;
                        next_bit_cnt  = 3'h0;
                        next_st       = rtc_host_pkg::S_BYTE;
                        if (!cfg.rw) begin
                           next_shreg = txd[{byte_idx, 3'h0} +: 8];
                        end
                     end
                  end
                  default: begin
                     next_st       = rtc_host_pkg::S_IDLE;
                     next_rec_mode = 1'h0;
                  end
               endcase
            end
         end
      endcase
      next_flags.busy  = (next_st != rtc_host_pkg::S_IDLE) && (next_st != rtc_host_pkg::S_HOLD);
      next_flags.ready = (next_st != rtc_host_pkg::S_HOLD);
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st       <= rtc_host_pkg::S_HOLD;
         cfg      <= rtc_host_pkg::ctrl_t'(`CTRL_RST);
         flags    <= '0;
         op_go    <= 1'h0;
         op_kind  <= rtc_host_pkg::OP_BIT;
         op_bit   <= 1'h1;
         pend     <= 1'h0;
         rec_mode <= 1'h0;
         st2_done <= 1'h0;
         armed    <= 1'h0;
         bit_cnt  <= 3'h0;
         byte_idx <= 3'h0;
         rec_cnt  <= 6'h0;
         shreg    <= 8'h0;
         txd      <= 64'h0;
         rxd      <= 64'h0;
         hold_cnt <= HW'(HOLD_CYC - 1);
         late_cnt <= '0;
         scl_o    <= 1'h0;
         sda_o    <= 1'h0;
      end else begin
         st       <= next_st;
         cfg      <= next_cfg;
         flags    <= next_flags;
         op_go    <= next_op_go;
         op_kind  <= next_op_kind;
         op_bit   <= next_op_bit;
         pend     <= next_pend;
         rec_mode <= next_rec_mode;
         st2_done <= next_st2_done;
         armed    <= next_armed;
         bit_cnt  <= next_bit_cnt;
         byte_idx <= next_byte_idx;
         rec_cnt  <= next_rec_cnt;
         shreg    <= next_shreg;
         txd      <= next_txd;
         rxd      <= next_rxd;
         hold_cnt <= next_hold_cnt;
         late_cnt <= next_late_cnt;
         scl_o    <= 1'h0;
         sda_o    <= 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   cmd_first_a: assert property ((st == rtc_host_pkg::S_START) && op_done && !rec_mode
      |=> (st == rtc_host_pkg::S_BYTE) && (byte_idx == 3'h0) && (shreg[7:4] == `DEV_CODE))
      else $error("command byte not sent first");
   ack_low_a: assert property ((st == rtc_host_pkg::S_ACK) && !is_tx && !last && op_go |-> !op_bit)
      else $error("read byte not acknowledged");
   nack_last_a: assert property ((st == rtc_host_pkg::S_ACK) && !is_tx && last && op_done
      |=> (st == rtc_host_pkg::S_STOP) && op_bit)
      else $error("last read byte not followed by stop");
   rec_count_a: assert property ($rose(st == rtc_host_pkg::S_STOP) && rec_mode |-> $past(rec_cnt) == 6'h3e)
      else $error("recovery clock count wrong");
   rec_release_a: assert property ((st == rtc_host_pkg::S_REC) && pend |-> op_bit && (op_kind == rtc_host_pkg::OP_BIT))
      else $error("data driven during recovery");
   hold_quiet_a: assert property ((st == rtc_host_pkg::S_HOLD) |-> !scl_oe && !sda_oe && !op_go)
      else $error("bus touched during power-on hold");
   init_rec_a: assert property ($fell(st == rtc_host_pkg::S_HOLD) |-> (st == rtc_host_pkg::S_START) && rec_mode)
      else $error("initial recovery not started");
   order_int_a: assert property (((st == rtc_host_pkg::S_IDLE) ##1 ((st == rtc_host_pkg::S_START)
      && !rec_mode && (cfg.cmd[2:1] == CMD_INT))) |-> $past(st2_done))
      else $error("interrupt register accessed before configuration");
   conflict_a: assert property (((st == rtc_host_pkg::S_IDLE) ##1 ((st == rtc_host_pkg::S_START)
      && !rec_mode && (cfg.cmd == CMD_ST2) && !cfg.rw))
      |-> !((($past(txd[7:0]) & ALARM_ON) == ALARM_ON) && (($past(txd[7:0]) & FREQ_ON) == FREQ_ON)))
      else $error("conflicting interrupt configuration sent");
   late_flag_a: assert property (armed && (late_cnt == '0) |=> flags.late && !armed)
      else $error("read-back deadline not flagged");
endmodule // rtc_host
`default_nettype wire

// >>> sim/rtc_dev_model.sv
// Behavioural serial clock device answering the host controller
`timescale 1ns/100ps
`default_nettype none
`include "rtc_host_defines.svh"
module rtc_dev_model (
   input  wire logic scl,
   input  wire logic sda,
   output logic      sda_pull
);
   logic [7:0] mem [8][8];
   logic [7:0] sh;
   logic [2:0] cmd;
   logic       act;
   logic       rw;
   int         bc;
   int         idx;
   initial begin
      sda_pull = 1'b0;
      act = 1'b0;
   end
   // Edges made while we pull low are our own, never start or stop
   always @(negedge sda) if (scl === 1'b1 && !sda_pull) begin
      act = 1'b1;
      bc = -1;
      idx = 0;
   end
   always @(posedge sda) if (scl === 1'b1 && !sda_pull) act = 1'b0;
   always @(posedge scl) if (act) begin
      if (bc < 8) sh = {sh[6:0], sda};
      else if (rw && idx > 0 && sda) act = 1'b0;
   end
   always @(negedge scl) begin
      sda_pull = 1'b0;
      if (act) begin
         bc++;
         if (bc == 8 && (idx == 0 || !rw)) begin
            if (idx == 0) begin
               rw = sh[0];
               cmd = sh[3:1];
               act = (sh[7:4] == `DEV_CODE);
            end else mem[cmd][idx-1] = sh;
            sda_pull = act;
         end
         if (bc == 9) begin
            bc = 0;
            idx++;
         end
         if (act && rw && idx > 0 && bc < 8) sda_pull = ~mem[cmd][idx-1][7-bc];
      end
   end
endmodule // rtc_dev_model
`default_nettype wire

// >>> sim/tb_rtc_host.sv
// Self-checking bench for the RTC host controller
`timescale 1ns/100ps
`default_nettype none
`include "rtc_host_defines.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_rtc_host;
   logic        ref_clk = 1'b0;
   logic        resetn  = 1'b1;
   logic        hsel    = 1'b0;
   logic [31:0] haddr   = 32'h0;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        scl_oe;
   logic        sda_oe;
   logic        pull;
   logic [31:0] got;
   logic [31:0] e;
   logic [31:0] m;
   logic [31:0] seed    = 32'h144db;
   logic [7:0]  wb;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          fails   = 0;
   int          checked = 0;
   event        got_ev;
   wire         scl     = !scl_oe;
   wire         sda     = !(sda_oe || pull);
   always #5 ref_clk = !ref_clk;
   rtc_host #(.HOLD_CYC(20), .LATE_CYC(2000), .QTR_CYC(25)) dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .scl_o(), .scl_oe(scl_oe), .sda_i(sda),
      .sda_o(), .sda_oe(sda_oe));
   rtc_dev_model u_dev (.scl(scl), .sda(sda), .sda_pull(pull));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 100);
      got = hrdata;
   endtask
   task automatic note(input logic [31:0] x, input logic [31:0] k);
      exp_q.push_back(x & k);
      msk_q.push_back(k);
      -> got_ev;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] k);
      bus(1'b0, a, 32'h0);
      note(x, k);
   endtask
   task automatic go(input rtc_host_pkg::ctrl_t c);
      bus(1'b1, `OFF_CTRL, {23'h0, c, 1'b1});
   endtask
   // Poll until out of power-on hold and the sequencer is free
   task automatic idle();
      int n;
      n = 0;
      do bus(1'b0, `OFF_STAT, 32'h0); while ((got[0] !== 1'b0 || got[1] !== 1'b1) && ++n < 10000);
      if (n >= 10000) fails++;
   endtask
   task automatic finish_test();
      @(posedge ref_clk);
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(got_ev) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(got & m, e)
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      fails++;
      finish_test();
   end
   initial begin
      // A real falling edge, so the asynchronous reset is seen
      resetn <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         u_dev.mem[0][k] = seed[7:0];
      end
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      rd(`OFF_STAT, 32'h0, 32'h2);
      bus(1'b1, `OFF_CTRL, 32'h1fe);
      rd(`OFF_CTRL, 32'h0, 32'h1fe);
      idle();
      rd(`OFF_STAT, 32'h2, 32'h3f);
      // Let the checker take the previous result first
      @(posedge ref_clk);
      got = {30'h0, scl, sda};
      note(32'h3, 32'h3);
      rd(8'h18, 32'h0, 32'hffffffff);
      $display("test power-on done");
      go('{3'h4, 1'b0, 3'h1, 1'b0});
      rd(`OFF_STAT, 32'h8, 32'h9);
      bus(1'b1, `OFF_STAT, 32'h3c);
      bus(1'b1, `OFF_TXLO, 32'h60);
      go('{3'h1, 1'b0, 3'h1, 1'b0});
      rd(`OFF_STAT, 32'h10, 32'h19);
      bus(1'b1, `OFF_STAT, 32'h3c);
      $display("test refusals done");
      seed = xs(seed);
      wb = seed[7:0] & 8'hbf;
      bus(1'b1, `OFF_TXLO, {24'h0, wb});
      go('{3'h1, 1'b0, 3'h1, 1'b0});
      idle();
      got = {24'h0, u_dev.mem[1][0]};
      note({24'h0, wb}, 32'hff);
      rd(`OFF_STAT, 32'h0, 32'h1d);
      // Late flag needs no read inside the shortened window
      repeat (2010) @(posedge ref_clk);
      rd(`OFF_STAT, 32'h20, 32'h20);
      $display("test write done");
      go('{3'h0, 1'b0, 3'h2, 1'b1});
      idle();
      rd(`OFF_RXLO, {16'h0, u_dev.mem[0][1], u_dev.mem[0][0]}, 32'hffff);
      rd(`OFF_STAT, 32'h0, 32'h5);
      $display("test read done");
      go('{3'h4, 1'b0, 3'h0, 1'b0});
      idle();
      got = {29'h0, u_dev.cmd};
      note(32'h4, 32'h7);
      rd(`OFF_STAT, 32'h0, 32'h1d);
      $display("test interrupt access done");
      finish_test();
   end
endmodule // tb_rtc_host
`default_nettype wire
